/* rtl/ctc_codec.sv */
// cassette tape record encoder and decoder
// ----------------------------------------
// Function
// - request code 0 motor on, 1 off, 2 read block, 3 write block, with address and count.
// - status 00 ok, 01 crc error, 02 no transitions, 04 no leader, 80 bad request.
// - any nonzero status also raises the separate error flag.
// - read and write switch the motor on at start and off at end.
// - writing sends one zero sync bit, then a 256-byte all-ones leader.
// - data goes in 256-byte blocks, each followed by two crc bytes.
// - a one bit is a 1.0 ms square cycle, a zero 0.5 ms.
// - the tone counter period is reloaded on the fly, keeping the wave continuous.
// - a short last block is padded by repeating the last data byte.
// - after the last block a four-byte all-ones trailer, then motor off.
// - a block write always ends with status 00.
// - a read waits about 0.5 s after motor on before looking at the tape.
// - a quarter leader of continuous ones is needed before the sync search.
// - the sync byte must be 16 hex, otherwise the leader search restarts.
// - read bytes go to the buffer address, which then advances; the count is returned.
// - after each 256 read bytes the crc is checked; mismatch ends with 01.
// - the block check is crc-16 x^16+x^12+x^5+1 over every data bit.
// - the complement of the crc register is written to tape.
// - the time-of-day tick is held off during a read and restored after.
// - record order is leader, sync byte 16 hex, then blocks with crc.
// ----------------------------------------
`timescale 1ns/1ps
`include "ctc_defs.svh"
module ctc_codec import ctc_pkg::*; #(
	parameter int unsigned ONE_CYC = `CTC_ONE_US * `CTC_CLK_MHZ,
	parameter int unsigned ZERO_CYC = `CTC_ZERO_US * `CTC_CLK_MHZ,
	parameter int unsigned SETTLE_CYC = `CTC_SETTLE_MS * `CTC_US_PER_MS * `CTC_CLK_MHZ,
	parameter int unsigned MAX_TRIES = 16
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic req_valid_i,
	input wire logic [7:0] request_status_code_i,
	input wire logic [15:0] buffer_segment_i,
	input wire logic [15:0] buffer_offset_i,
	input wire logic [15:0] byte_count_param_i,
	input wire logic [7:0] mem_rdata_i,
	input wire logic mem_ack_i,
	input wire logic tape_in_i,
	input wire logic tick_interrupt_line_i,
	output logic busy_o,
	output logic done_o,
	output logic error_o,
	output logic [7:0] request_status_code_o,
	output logic [15:0] bytes_done_count_o,
	output logic motor_o,
	output logic tape_out_o,
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [19:0] mem_addr_o,
	output logic [7:0] mem_wdata_o,
	output logic tick_interrupt_line_o
);
	localparam int unsigned TO_CYC = 2 * ONE_CYC;
	localparam int unsigned CW = $clog2(TO_CYC + 1);
	localparam int unsigned SW = $clog2(SETTLE_CYC);
	localparam logic [CW-1:0] THRESH_C = CW'((ONE_CYC + ZERO_CYC) / 2);
	localparam logic [CW-1:0] TO_C = CW'(TO_CYC);
	localparam logic [SW-1:0] SETTLE_C = SW'(SETTLE_CYC - 1);
	localparam logic [7:0] TRY_C = 8'(MAX_TRIES - 1);

	// segment:offset to a 20-bit buffer address
	function automatic logic [19:0] buf_addr(input logic [15:0] seg, input logic [15:0] off);
		buf_addr = {seg, 4'h0} + {4'h0, off};
	endfunction : buf_addr

	logic [1:0] rst_q;
	logic rst_n;
	ctc_state_t st_q;
	ctc_wph_t wph_q;
	logic [15:0] seg_q, off_q, cnt_q, done_cnt_q, crc_q;
	logic [7:0] blk_q, pcnt_q, wsh_q, last_q, rsh_q, rcrc_q, tries_q, status_q;
	logic [3:0] wbits_q;
	logic [2:0] rbits_q, tin_q;
	logic [9:0] ones_q;
	logic [SW-1:0] settle_q;
	logic [CW-1:0] iv_q;
	logic crc_idx_q, wdata_q, motor_q, done_q, err_q, busy_q, tick_q;
	logic mem_req_q, mem_we_q;
	logic [19:0] mem_addr_q;
	logic [7:0] mem_wdata_q;
	logic rd_act, rd_scan, rise, rbit, rbit_v, byte_done, notrans, more;
	logic [7:0] rbyte;
	logic take, tone_idle, wr_gap, sup_v, crc_clr, fin_v, crc_bad;
	logic [7:0] sup_b, fin_code;

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_q <= 2'b00;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_n = rst_q[1];

	// ----------------------------------------
	// read front end
	// ----------------------------------------
	// tape pin through two flops, third flop only for the edge
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tin_q <= 3'b000;
		end else begin
			tin_q <= {tin_q[1], tin_q[0], tape_in_i};
		end
	end

	assign rd_act = (st_q != ST_IDLE) && (st_q != ST_WR);
	assign rd_scan = rd_act && (st_q != ST_SETTLE);
	assign rise = tin_q[1] & ~tin_q[2];
	assign rbit_v = rise && rd_scan;
	assign rbit = (iv_q >= THRESH_C);
	assign notrans = rd_scan && (iv_q == TO_C);
	assign rbyte = {rsh_q[6:0], rbit};
	assign byte_done = rbit_v && (rbits_q == 3'h7);
	assign more = (done_cnt_q < cnt_q);
	assign crc_bad = ({rcrc_q, rbyte} != ~crc_q);

	// interval since the last rising edge; saturates at the timeout
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			iv_q <= '0;
		end else if (!rd_scan || rise) begin
			iv_q <= '0;
		end else if (!notrans) begin
			iv_q <= iv_q + 1'b1;
		end
	end

	// ----------------------------------------
	// write serializer
	// ----------------------------------------
	assign wr_gap = (st_q == ST_WR) && (wbits_q == 4'h0);

	// next byte for the tape; a fetch must land within one bit period
	always_comb begin
		sup_v = wr_gap;
		sup_b = `CTC_ONES_BYTE;
		unique case (wph_q)
			PH_SYNCBIT: sup_b = `CTC_ZERO_BYTE;
			PH_LEADER: sup_b = `CTC_ONES_BYTE;
			PH_SYNCBYTE: sup_b = `CTC_SYNC_BYTE;
			PH_DATA: begin
				if (more) begin
					sup_v = wr_gap && mem_req_q && mem_ack_i;
					sup_b = mem_rdata_i;
				end else begin
					sup_b = last_q;
				end
			end
			PH_CRC: sup_b = pcnt_q[0] ? ~crc_q[7:0] : ~crc_q[15:8];
			PH_TRAILER: sup_b = `CTC_ONES_BYTE;
			PH_DRAIN: sup_v = 1'b0;
			default: sup_v = 1'b0;
		endcase
	end

	// shift register feeding the tone generator msb first
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			wsh_q <= 8'h00;
			wbits_q <= 4'h0;
			wdata_q <= 1'b0;
		end else if (st_q != ST_WR) begin
			wbits_q <= 4'h0;
			wdata_q <= 1'b0;
		end else if (sup_v) begin
			wsh_q <= sup_b;
			wbits_q <= (wph_q == PH_SYNCBIT) ? 4'h1 : 4'h8;
			wdata_q <= (wph_q == PH_DATA);
		end else if (take) begin
			wsh_q <= {wsh_q[6:0], 1'b0};
			wbits_q <= wbits_q - 1'b1;
		end
	end

	ctc_tone_gen #(
		.ONE_CYC(ONE_CYC),
		.ZERO_CYC(ZERO_CYC),
		.CW(CW)
	) u_tone (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.bit_valid_i(wbits_q != 4'h0),
		.bit_i(wsh_q[7]),
		.take_o(take),
		.idle_o(tone_idle),
		.tone_o(tape_out_o)
	);

	// ----------------------------------------
	// block check
	// ----------------------------------------
	assign crc_clr = (sup_v && wph_q == PH_SYNCBYTE) || (sup_v && wph_q == PH_CRC && pcnt_q[0])
		|| (st_q == ST_SYNCB && byte_done) || (st_q == ST_CRC && byte_done && crc_idx_q);

	// data bits only; crc bytes themselves never enter the register
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			crc_q <= `CTC_CRC_INIT;
		end else if (crc_clr) begin
			crc_q <= `CTC_CRC_INIT;
		end else if (take && wdata_q) begin
			crc_q <= ctc_crc_step(crc_q, wsh_q[7]);
		end else if (rbit_v && st_q == ST_DATA) begin
			crc_q <= ctc_crc_step(crc_q, rbit);
		end
	end

	// ----------------------------------------
	// completion decode
	// ----------------------------------------
	always_comb begin
		fin_v = 1'b0;
		fin_code = `CTC_ST_OK;
		if (st_q == ST_IDLE) begin
			if (req_valid_i && request_status_code_i != `CTC_REQ_READ
				&& request_status_code_i != `CTC_REQ_WRITE) begin
				fin_v = 1'b1;
				if (request_status_code_i != `CTC_REQ_MOTOR_ON
					&& request_status_code_i != `CTC_REQ_MOTOR_OFF) begin
					fin_code = `CTC_ST_BADREQ;
				end
			end
		end else if (notrans) begin
			fin_v = 1'b1;
			fin_code = `CTC_ST_NOTRANS;
		end else if (tries_q == TRY_C && ((st_q == ST_LEADER && rbit_v && !rbit)
			|| (st_q == ST_SYNCB && byte_done && rbyte != `CTC_SYNC_BYTE))) begin
			fin_v = 1'b1;
			fin_code = `CTC_ST_NOLEAD;
		end else if (st_q == ST_SYNCB && byte_done && rbyte == `CTC_SYNC_BYTE) begin
			fin_v = (cnt_q == 16'h0000);
		end else if (st_q == ST_CRC && byte_done && crc_idx_q) begin
			fin_v = crc_bad || !more;
			fin_code = crc_bad ? `CTC_ST_CRC : `CTC_ST_OK;
		end else if (st_q == ST_WR && wph_q == PH_DRAIN) begin
			fin_v = (wbits_q == 4'h0) && tone_idle;
		end
	end

	// status and error outputs hold until the next request completes; done is a one-cycle pulse
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			done_q <= 1'b0;
			status_q <= `CTC_ST_OK;
			err_q <= 1'b0;
		end else begin
			done_q <= fin_v;
			if (fin_v) begin
				status_q <= fin_code;
				err_q <= (fin_code != `CTC_ST_OK);
			end
		end
	end

	// ----------------------------------------
	// motor and tick gate
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			motor_q <= 1'b0;
		end else if (st_q == ST_IDLE && req_valid_i) begin
			if (request_status_code_i == `CTC_REQ_MOTOR_OFF) begin
				motor_q <= 1'b0;
			end else if (request_status_code_i <= `CTC_REQ_WRITE) begin
				motor_q <= 1'b1;
			end
		end else if (fin_v) begin
			motor_q <= 1'b0;
		end
	end

	// tick passes through unchanged except while a read is running
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= tick_interrupt_line_i && !rd_act;
		end
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= ST_IDLE;
			wph_q <= PH_SYNCBIT;
			{seg_q, off_q, cnt_q, done_cnt_q} <= '0;
			{blk_q, pcnt_q, last_q, rsh_q, rcrc_q, tries_q} <= '0;
			{rbits_q, ones_q, settle_q, crc_idx_q, busy_q} <= '0;
			{mem_req_q, mem_we_q, mem_addr_q, mem_wdata_q} <= '0;
		end else begin
			if (mem_ack_i) begin
				mem_req_q <= 1'b0;
			end
			if (rbit_v) begin
				rsh_q <= rbyte;
			end
			if (st_q == ST_IDLE) begin
				if (req_valid_i && !fin_v) begin
					seg_q <= buffer_segment_i;
					off_q <= buffer_offset_i;
					cnt_q <= byte_count_param_i;
					done_cnt_q <= 16'h0000;
					tries_q <= 8'h00;
					settle_q <= '0;
					wph_q <= PH_SYNCBIT;
					pcnt_q <= 8'h00;
					busy_q <= 1'b1;
					st_q <= (request_status_code_i == `CTC_REQ_READ) ? ST_SETTLE : ST_WR;
				end
			end else if (fin_v) begin
				st_q <= ST_IDLE;
				busy_q <= 1'b0;
			end else begin
				unique case (st_q)
					ST_SETTLE: begin
						settle_q <= settle_q + 1'b1;
						if (settle_q == SETTLE_C) begin
							st_q <= ST_LEADER;
							ones_q <= 10'h000;
						end
					end
					ST_LEADER: begin
						if (rbit_v && rbit) begin
							ones_q <= ones_q + 1'b1;
							if (ones_q == `CTC_QUAL_LAST) begin
								st_q <= ST_SYNC;
							end
						end else if (rbit_v) begin
							ones_q <= 10'h000;
							tries_q <= tries_q + 1'b1;
						end
					end
					ST_SYNC: begin
						if (rbit_v && !rbit) begin
							rbits_q <= 3'h1;
							st_q <= ST_SYNCB;
						end
					end
					ST_SYNCB, ST_DATA, ST_CRC: begin
						if (rbit_v) begin
							rbits_q <= rbits_q + 1'b1;
						end
						if (byte_done && st_q == ST_SYNCB) begin
							blk_q <= 8'h00;
							ones_q <= 10'h000;
							if (rbyte == `CTC_SYNC_BYTE) begin
								st_q <= ST_DATA;
							end else begin
								st_q <= ST_LEADER;
								tries_q <= tries_q + 1'b1;
							end
						end else if (byte_done && st_q == ST_DATA) begin
							blk_q <= blk_q + 1'b1;
							if (more) begin
								mem_req_q <= 1'b1;
								mem_we_q <= 1'b1;
								mem_wdata_q <= rbyte;
								mem_addr_q <= buf_addr(seg_q, off_q);
								off_q <= off_q + 1'b1;
								done_cnt_q <= done_cnt_q + 1'b1;
							end
							if (blk_q == `CTC_BLK_LAST) begin
								st_q <= ST_CRC;
								crc_idx_q <= 1'b0;
							end
						end else if (byte_done) begin
							rcrc_q <= rbyte;
							crc_idx_q <= 1'b1;
							if (crc_idx_q) begin
								st_q <= ST_DATA;
								blk_q <= 8'h00;
							end
						end
					end
					ST_WR: begin
						if (wph_q == PH_DATA && more && wbits_q == 4'h0 && !mem_req_q
							&& !mem_ack_i) begin
							mem_req_q <= 1'b1;
							mem_we_q <= 1'b0;
							mem_addr_q <= buf_addr(seg_q, off_q);
						end
						if (sup_v) begin
							unique case (wph_q)
								PH_SYNCBIT: wph_q <= PH_LEADER;
								PH_LEADER: begin
									pcnt_q <= pcnt_q + 1'b1;
									if (pcnt_q == `CTC_LEADER_LAST) begin
										wph_q <= PH_SYNCBYTE;
									end
								end
								PH_SYNCBYTE: begin
									blk_q <= 8'h00;
									pcnt_q <= 8'h00;
									wph_q <= (cnt_q == 16'h0000) ? PH_TRAILER : PH_DATA;
								end
								PH_DATA: begin
									blk_q <= blk_q + 1'b1;
									if (more) begin
										last_q <= mem_rdata_i;
										off_q <= off_q + 1'b1;
										done_cnt_q <= done_cnt_q + 1'b1;
									end
									if (blk_q == `CTC_BLK_LAST) begin
										wph_q <= PH_CRC;
										pcnt_q <= 8'h00;
									end
								end
								PH_CRC: begin
									pcnt_q <= pcnt_q + 1'b1;
									blk_q <= 8'h00;
									if (pcnt_q[0]) begin
										wph_q <= more ? PH_DATA : PH_TRAILER;
										pcnt_q <= 8'h00;
									end
								end
								PH_TRAILER: begin
									pcnt_q <= pcnt_q + 1'b1;
									if (pcnt_q == `CTC_TRAILER_LAST) begin
										wph_q <= PH_DRAIN;
									end
								end
								default: wph_q <= PH_DRAIN;
							endcase
						end
					end
					default: st_q <= ST_IDLE;
				endcase
			end
		end
	end

	assign busy_o = busy_q;
	assign done_o = done_q;
	assign error_o = err_q;
	assign request_status_code_o = status_q;
	assign bytes_done_count_o = done_cnt_q;
	assign motor_o = motor_q;
	assign mem_req_o = mem_req_q;
	assign mem_we_o = mem_we_q;
	assign mem_addr_o = mem_addr_q;
	assign mem_wdata_o = mem_wdata_q;
	assign tick_interrupt_line_o = tick_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_err_with_status: assert property (@(posedge clk_i) disable iff (!rst_n)
		done_o |-> (error_o == (request_status_code_o != `CTC_ST_OK)))
		else $error("error flag disagrees with status");
	chk_bad_request: assert property (@(posedge clk_i) disable iff (!rst_n)
		(st_q == ST_IDLE && req_valid_i && request_status_code_i > `CTC_REQ_WRITE)
		|=> (done_o && request_status_code_o == `CTC_ST_BADREQ && st_q == ST_IDLE))
		else $error("bad request not answered with 80");
	chk_motor_cmd: assert property (@(posedge clk_i) disable iff (!rst_n)
		(st_q == ST_IDLE && req_valid_i && request_status_code_i == `CTC_REQ_MOTOR_ON)
		|=> (motor_o && done_o && !busy_o))
		else $error("motor on request not honoured");
	chk_motor_auto: assert property (@(posedge clk_i) disable iff (!rst_n)
		(busy_o && !$past(busy_o)) |-> motor_o ##1 (busy_o || !motor_o))
		else $error("motor not managed around a block operation");
	chk_write_clean: assert property (@(posedge clk_i) disable iff (!rst_n)
		(st_q == ST_WR && fin_v) |=> (done_o && !error_o && !motor_o))
		else $error("write ended with an error or motor on");
	chk_tick_held: assert property (@(posedge clk_i) disable iff (!rst_n)
		rd_act |=> !tick_interrupt_line_o)
		else $error("tick passed during a read");
	chk_crc_fail: assert property (@(posedge clk_i) disable iff (!rst_n)
		(st_q == ST_CRC && byte_done && crc_idx_q && crc_bad)
		|=> (done_o && request_status_code_o == `CTC_ST_CRC && st_q == ST_IDLE))
		else $error("crc mismatch not reported as 01");
	chk_sync_retry: assert property (@(posedge clk_i) disable iff (!rst_n)
		(st_q == ST_SYNCB && byte_done && rbyte != `CTC_SYNC_BYTE && tries_q != TRY_C)
		|=> (st_q == ST_LEADER && ones_q == 10'h000))
		else $error("wrong sync byte did not restart leader search");
	chk_store_step: assert property (@(posedge clk_i) disable iff (!rst_n)
		(st_q == ST_DATA && byte_done && more && !fin_v)
		|=> (mem_req_o && mem_we_o && mem_wdata_o == $past(rbyte)
		&& off_q == $past(off_q) + 16'h0001))
		else $error("read byte not stored or address not advanced");

endmodule : ctc_codec

/* rtl/ctc_defs.svh */
// constants of the cassette tape record codec
`ifndef CTC_DEFS_SVH
`define CTC_DEFS_SVH
// ----------------------------------------
// timing, in the units as specified
// ----------------------------------------
`define CTC_CLK_MHZ 100
`define CTC_ONE_US 1000
`define CTC_ZERO_US 500
`define CTC_SETTLE_MS 500
`define CTC_US_PER_MS 1000
// ----------------------------------------
// request and status codes
// ----------------------------------------
`define CTC_REQ_MOTOR_ON 8'h00
`define CTC_REQ_MOTOR_OFF 8'h01
`define CTC_REQ_READ 8'h02
`define CTC_REQ_WRITE 8'h03
`define CTC_ST_OK 8'h00
`define CTC_ST_CRC 8'h01
`define CTC_ST_NOTRANS 8'h02
`define CTC_ST_NOLEAD 8'h04
`define CTC_ST_BADREQ 8'h80
// ----------------------------------------
// record layout
// ----------------------------------------
`define CTC_ONES_BYTE 8'hff
`define CTC_ZERO_BYTE 8'h00
`define CTC_SYNC_BYTE 8'h16
`define CTC_LEADER_LAST 8'hff
`define CTC_BLK_LAST 8'hff
`define CTC_TRAILER_LAST 8'h03
`define CTC_QUAL_LAST 10'h1ff
`define CTC_CRC_POLY 16'h1021
`define CTC_CRC_INIT 16'hffff
`define CTC_CRC_ZERO 16'h0000
`endif

/* rtl/ctc_pkg.sv */
// types and the shared crc step of the cassette tape record codec
package ctc_pkg;
`include "ctc_defs.svh"

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SETTLE = 3'b001,
		ST_LEADER = 3'b010,
		ST_SYNC = 3'b011,
		ST_SYNCB = 3'b100,
		ST_DATA = 3'b101,
		ST_CRC = 3'b110,
		ST_WR = 3'b111
	} ctc_state_t;

	typedef enum logic [2:0] {
		PH_SYNCBIT = 3'b000,
		PH_LEADER = 3'b001,
		PH_SYNCBYTE = 3'b010,
		PH_DATA = 3'b011,
		PH_CRC = 3'b100,
		PH_TRAILER = 3'b101,
		PH_DRAIN = 3'b110
	} ctc_wph_t;

	// one msb-first step of the x^16+x^12+x^5+1 check
	function automatic logic [15:0] ctc_crc_step(input logic [15:0] crc, input logic b);
		ctc_crc_step = {crc[14:0], 1'b0} ^ ((crc[15] ^ b) ? `CTC_CRC_POLY : `CTC_CRC_ZERO);
	endfunction : ctc_crc_step

endpackage : ctc_pkg

/* rtl/ctc_tone_gen.sv */
// square-wave bit tone generator with on-the-fly period reload
`timescale 1ns/1ps
module ctc_tone_gen import ctc_pkg::*; #(
	parameter int unsigned ONE_CYC = 100000,
	parameter int unsigned ZERO_CYC = 50000,
	parameter int unsigned CW = 18
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic bit_valid_i,
	input wire logic bit_i,
	output logic take_o,
	output logic idle_o,
	output logic tone_o
);
	localparam logic [CW-1:0] ONE_C = CW'(ONE_CYC - 1);
	localparam logic [CW-1:0] ZERO_C = CW'(ZERO_CYC - 1);
	localparam logic [CW-1:0] ONE_H = CW'(ONE_CYC / 2);
	localparam logic [CW-1:0] ZERO_H = CW'(ZERO_CYC / 2);

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] half_q;
	logic tone_q;

	// a new bit is taken in the last cycle of the previous one, so no gap appears
	assign idle_o = (cnt_q == '0);
	assign take_o = idle_o && bit_valid_i;
	assign tone_o = tone_q;

	// ----------------------------------------
	// period counter
	// ----------------------------------------
	// high for the first half of the period, low for the rest
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= '0;
			half_q <= '0;
			tone_q <= 1'b0;
		end else if (take_o) begin
			cnt_q <= bit_i ? ONE_C : ZERO_C;
			half_q <= bit_i ? ONE_H : ZERO_H;
			tone_q <= 1'b1;
		end else if (!idle_o) begin
			cnt_q <= cnt_q - 1'b1;
			if (cnt_q == half_q) begin
				tone_q <= 1'b0;
			end
		end else begin
			tone_q <= 1'b0;
		end
	end

	chk_tone_one_half: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(take_o && bit_i) |=> (tone_o && half_q == ONE_H && cnt_q == ONE_C))
		else $error("one bit did not start a full-length high half");

endmodule : ctc_tone_gen

/* tb/ctc_tape_model.sv */
// behavioural cassette recorder that plays a record back when the motor starts
`timescale 1ns/1ps
module ctc_tape_model #(
	parameter int unsigned ONE_CYC = 8,
	parameter int unsigned ZERO_CYC = 4
) (
	input wire logic clk_i,
	input wire logic motor_i,
	input wire logic [1:0] mode_i,
	output logic tape_o
);
	// ----------------------------------------
	// playback of one record per motor start
	// ----------------------------------------
	logic [15:0] crc;
	int k;
	// one full square cycle per bit, high half first
	task automatic tone(input logic b);
		int n;
		n = b ? ONE_CYC : ZERO_CYC;
		tape_o = 1'b1;
		repeat (n / 2) @(posedge clk_i);
		#1 tape_o = 1'b0;
		repeat (n - n / 2) @(posedge clk_i);
		#1;
	endtask : tone
	task automatic send(input logic [7:0] v, input logic upd);
		for (int j = 7; j >= 0; j--) begin
			tone(v[j]);
			if (upd) crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ v[j]) ? 16'h1021 : 16'h0000);
		end
	endtask : send
	// mode 2 keeps the tape blank, mode 1 spoils the check word on purpose
	initial begin
		tape_o = 1'b0;
		forever begin
			@(posedge motor_i);
			repeat (10) @(posedge clk_i);
			#1;
			if (mode_i != 2'd2) begin
				crc = 16'hffff;
				for (k = 0; k < 520; k++) tone(1'b1);
				send(8'h16, 1'b0);
				for (k = 0; k < 256; k++) send(8'(k) ^ 8'h5a, 1'b1);
				if (mode_i == 2'd1) crc = crc ^ 16'h0001;
				send(~crc[15:8], 1'b0);
				send(~crc[7:0], 1'b0);
				for (k = 0; k < 8; k++) tone(1'b1);
			end
		end
	end
endmodule : ctc_tape_model

/* tb/cassette_tape_record_codec_tb_top.sv */
// self-checking bench of the cassette tape record codec
`timescale 1ns/1ps
`include "ctc_defs.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module cassette_tape_record_codec_tb_top;
	// ----------------------------------------
	// stimulus, memory, tape watcher
	// ----------------------------------------
	logic clk_i = 0, rst_n_i = 0, req_valid_i = 0, mem_ack_i = 0, tick_i = 1;
	logic [7:0] code_i = 0, mem_rdata_i = 0;
	logic [15:0] seg_i = 0, off_i = 0, cnt_i = 0, crc;
	logic [1:0] mode = 2'd2;
	logic busy_o, done_o, error_o, motor_o, tape_out_o, mem_req_o, mem_we_o, tick_o, tape_in;
	logic [7:0] status_o, mem_wdata_o;
	logic [15:0] count_o;
	logic [19:0] mem_addr_o;
	logic tprev = 0, seen = 0;
	logic q_got[$], q_exp[$];
	logic [7:0] mem [0:1023];
	int n_mismatch = 0, samples_checked = 0, cyc = 0, tcnt = 0;
	ctc_codec #(.ONE_CYC(8), .ZERO_CYC(4), .SETTLE_CYC(16)) u_ctc_codec (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .request_status_code_i(code_i),
		.buffer_segment_i(seg_i), .buffer_offset_i(off_i), .byte_count_param_i(cnt_i),
		.mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i), .tape_in_i(tape_in),
		.tick_interrupt_line_i(tick_i), .busy_o(busy_o), .done_o(done_o), .error_o(error_o),
		.request_status_code_o(status_o), .bytes_done_count_o(count_o), .motor_o(motor_o),
		.tape_out_o(tape_out_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
		.mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .tick_interrupt_line_o(tick_o));
	// the model's default bit periods already match the short periods given to the codec
	ctc_tape_model u_ctc_tape_model (.clk_i(clk_i),
		.motor_i(motor_o), .mode_i(mode), .tape_o(tape_in));
	always #5 clk_i = ~clk_i;
	function automatic logic [7:0] pat(input logic [15:0] a);
		return a[7:0] ^ 8'h5a;
	endfunction : pat
	// memory answers one cycle after a request, ack is a single-cycle pulse
	always @(posedge clk_i) begin
		if (mem_req_o && !mem_ack_i) begin
			mem_ack_i <= #1 1'b1;
			mem_rdata_i <= #1 pat(mem_addr_o[15:0]);
			if (mem_we_o) mem[mem_addr_o[9:0]] = mem_wdata_o;
		end else mem_ack_i <= #1 1'b0;
	end
	// bit decode of the written wave by rise-to-rise period; the last bit has no closing rise
	always @(posedge clk_i) begin
		if (tape_out_o && !tprev) begin
			if (seen) q_got.push_back(tcnt >= 6);
			tcnt = 1;
			seen = 1;
		end else tcnt++;
		tprev = tape_out_o;
		cyc++;
		if (cyc == 90000) begin
			n_mismatch++;
			results();
		end
	end
	task automatic req(input logic [7:0] c, input logic [15:0] s, o, n);
		@(posedge clk_i);
		#1 {req_valid_i, code_i, seg_i, off_i, cnt_i} = {1'b1, c, s, o, n};
		@(posedge clk_i);
		#1 req_valid_i = 0;
	endtask : req
	task automatic wait_done;
		for (int i = 0; i < 40000 && done_o !== 1'b1; i++) begin
			@(posedge clk_i);
			#1;
		end
		`CHK(done_o, 1'b1)
	endtask : wait_done
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic motor_codes;
		logic [7:0] cd [3] = '{8'h00, 8'h05, 8'h01};
		logic [7:0] st [3] = '{`CTC_ST_OK, `CTC_ST_BADREQ, `CTC_ST_OK};
		logic mo [3] = '{1'b1, 1'b1, 1'b0};
		for (int i = 0; i < 3; i++) begin
			req(cd[i], 16'h0000, 16'h0000, 16'h0000);
			`CHK(done_o, 1'b1)
			`CHK(status_o, st[i])
			`CHK(error_o, st[i] != 8'h00)
			`CHK(motor_o, mo[i])
		end
	endtask : motor_codes
	task automatic pushb(input logic [7:0] v, input logic upd);
		for (int j = 7; j >= 0; j--) begin
			q_exp.push_back(v[j]);
			if (upd) crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ v[j]) ? 16'h1021 : 16'h0000);
		end
	endtask : pushb
	// three bytes force padding of the only block by the last byte
	task automatic write_rec;
		int bad;
		q_got.delete();
		q_exp.delete();
		seen = 0;
		crc = 16'hffff;
		bad = 0;
		q_exp.push_back(1'b0);
		for (int i = 0; i < 256; i++) pushb(8'hff, 1'b0);
		pushb(8'h16, 1'b0);
		for (int i = 0; i < 256; i++) pushb(pat(16'(i > 2 ? 2 : i)), 1'b1);
		pushb(~crc[15:8], 1'b0);
		pushb(~crc[7:0], 1'b0);
		for (int i = 0; i < 31; i++) q_exp.push_back(1'b1);
		req(8'h03, 16'h0000, 16'h0100, 16'h0003);
		`CHK(motor_o, 1'b1)
		wait_done();
		`CHK(status_o, `CTC_ST_OK)
		`CHK(error_o, 1'b0)
		`CHK(motor_o, 1'b0)
		`CHK(count_o, 16'h0003)
		`CHK(q_got.size(), q_exp.size())
		for (int i = 0; i < q_exp.size() && i < q_got.size(); i++) bad += (q_got[i] !== q_exp[i]);
		`CHK(bad, 0)
	endtask : write_rec
	task automatic read_rec(input logic [1:0] m, input logic [7:0] st, input logic [15:0] n);
		mode = m;
		for (int i = 0; i < 4; i++) mem[256 + i] = 8'h00;
		req(8'h02, 16'h0010, 16'h0000, 16'h0003);
		`CHK(motor_o, 1'b1)
		// the tick gate follows one edge after the read state is entered
		@(posedge clk_i);
		#1;
		`CHK(busy_o, 1'b1)
		`CHK(tick_o, 1'b0)
		wait_done();
		`CHK(status_o, st)
		`CHK(error_o, st != 8'h00)
		`CHK(count_o, n)
		`CHK(motor_o, 1'b0)
		`CHK(busy_o, 1'b0)
		for (int i = 0; i < n; i++) `CHK(mem[256 + i], pat(16'(i)))
		repeat (200) @(posedge clk_i);
		// the restored tick must follow its input both ways
		#1 tick_i = 0;
		repeat (2) @(posedge clk_i);
		#1;
		`CHK(tick_o, 1'b0)
		tick_i = 1;
		repeat (2) @(posedge clk_i);
		#1;
		`CHK(tick_o, 1'b1)
	endtask : read_rec
	task automatic results;
		$display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : results
	initial begin
		repeat (5) @(posedge clk_i);
		#1 rst_n_i = 1;
		repeat (3) @(posedge clk_i);
		motor_codes();
		write_rec();
		read_rec(2'd0, `CTC_ST_OK, 16'h0003);
		read_rec(2'd1, `CTC_ST_CRC, 16'h0003);
		read_rec(2'd2, `CTC_ST_NOTRANS, 16'h0000);
		results();
	end
endmodule : cassette_tape_record_codec_tb_top
